// ### tb_top.sv
// self-checking bench for the temperature limit and alert logic
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic ext;
    logic [11:0] raw;
    logic [15:0] exp;
  } tla_row_s;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk, sys_rst, meas_valid, ext_range, mask_all, cfg_wr;
  logic status_clr, fault_status, crit_pin_oe, crit_pin_o;
  logic alert_comparator_pin_o, alert_comparator_pin_oe;
  tla_pkg::tla_meas_s [1:0] meas;
  tla_pkg::tla_mode_e alert_mode;
  tla_pkg::tla_limits_s [1:0] limits;
  logic [1:0] chan_mask, filter_wdata, filter_level;
  logic [1:0] high_status, low_status, crit_status;
  logic [7:0] hysteresis;
  logic [2:0] alert_queue, crit_queue;
  logic [5:0] ideality_wdata, ideality_factor;
  logic [1:0][7:0] temp_high_byte, temp_low_byte;
  int n_mismatch, checks;
  // pins and status packed for one compare: oe, coe, hi, lo, crit, fault
  wire [8:0] pins = {alert_comparator_pin_oe, crit_pin_oe, high_status,
                     low_status, crit_status, fault_status};
  wire [15:0] bytes1 = {temp_high_byte[1], temp_low_byte[1]};
  // table rows: range, raw eighths, expected internal bytes
  localparam tla_row_s ROWS [14] = '{
    '{1'h0, 12'h000, 16'h0000}, '{1'h0, 12'h001, 16'h0020},
    '{1'h0, 12'h008, 16'h0100}, '{1'h0, 12'h200, 16'h4000},
    '{1'h0, 12'h3ff, 16'h7fe0}, '{1'h0, 12'h400, 16'h7fe0},
    '{1'h0, 12'hff8, 16'h0000}, '{1'h1, 12'hff8, 16'h3f00},
    '{1'h1, 12'he00, 16'h0000}, '{1'h1, 12'hda8, 16'h0000},
    '{1'h1, 12'h000, 16'h4000}, '{1'h1, 12'h5f8, 16'hff00},
    '{1'h1, 12'h5ff, 16'hffe0}, '{1'h1, 12'h7d0, 16'hffe0}};

  tla_alert_logic uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .meas_valid(meas_valid), .meas(meas), .alert_mode(alert_mode),
    .ext_range(ext_range), .mask_all(mask_all), .chan_mask(chan_mask),
    .limits(limits), .hysteresis(hysteresis), .alert_queue(alert_queue),
    .crit_queue(crit_queue), .cfg_wr(cfg_wr),
    .ideality_wdata(ideality_wdata), .filter_wdata(filter_wdata),
    .status_clr(status_clr), .temp_high_byte(temp_high_byte),
    .temp_low_byte(temp_low_byte), .ideality_factor(ideality_factor),
    .filter_level(filter_level), .high_status(high_status),
    .low_status(low_status), .crit_status(crit_status),
    .fault_status(fault_status),
    .alert_comparator_pin_o(alert_comparator_pin_o),
    .alert_comparator_pin_oe(alert_comparator_pin_oe),
    .crit_pin_o(crit_pin_o), .crit_pin_oe(crit_pin_oe));
  tla_host_model host (.ref_clk(ref_clk), .alert_mode(alert_mode),
    .ext_range(ext_range), .mask_all(mask_all), .chan_mask(chan_mask),
    .limits(limits), .hysteresis(hysteresis), .alert_queue(alert_queue),
    .crit_queue(crit_queue), .cfg_wr(cfg_wr),
    .ideality_wdata(ideality_wdata), .filter_wdata(filter_wdata),
    .status_clr(status_clr));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
  endtask : do_reset
  // one round; waits past the pin stage so everything has settled
  task automatic round(input logic [11:0] r0, input logic [1:0] flt);
    @(posedge ref_clk);
    #1;
    meas_valid = 1'b1;
    meas = {12'h190, flt, r0, 2'h0};
    @(posedge ref_clk);
    #1;
    meas_valid = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : round

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #20us;
    n_mismatch++;
    finish_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {n_mismatch, checks, meas_valid} = '0;
    meas = '0;
    do_reset();
    check({ideality_factor, filter_level}, 16'h0048);
    check(pins, 16'h0000);
    foreach (ROWS[i]) begin
      host.ext_range = ROWS[i].ext;
      round(ROWS[i].raw, 2'h0);
      check({temp_high_byte[0], temp_low_byte[0]}, ROWS[i].exp);
      // external channel follows its own raw value with the filter off
      check(bytes1, ROWS[i].ext ? 16'h7200 : 16'h3200);
    end
    // interrupt mode, two-round queue, latch, global mask, clear
    do_reset();
    host.ext_range = 1'b0;
    host.limits[0].high = 11'h320;
    host.alert_queue = 3'h2;
    round(12'h320, 2'h0);
    check(pins, 16'h0000);
    round(12'h320, 2'h0);
    check(pins, 16'h0120);
    round(12'h190, 2'h0);
    check(pins, 16'h0120);
    host.mask_all = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(pins, 16'h0020);
    host.mask_all = 1'b0;
    host.strobe(1'b1, 6'h12, 2'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    check(pins, 16'h0000);
    // comparator mode: strict above, hysteresis, masks
    do_reset();
    host.alert_mode = tla_pkg::TLA_MODE_COMPARATOR;
    host.alert_queue = 3'h1;
    round(12'h320, 2'h0);
    check(pins, 16'h0000);
    round(12'h321, 2'h0);
    check(pins, 16'h0120);
    host.strobe(1'b1, 6'h12, 2'h0);
    check(pins, 16'h0120);
    round(12'h316, 2'h0);
    check(pins, 16'h0120);
    round(12'h30f, 2'h0);
    check(pins, 16'h0000);
    {host.mask_all, host.chan_mask} = 3'h5;
    round(12'h321, 2'h0);
    check(pins, 16'h0000);
    host.chan_mask = 2'h0;
    round(12'h321, 2'h0);
    check(pins, 16'h0120);
    // critical pin ignores every mask and has its own hysteresis
    do_reset();
    host.alert_mode = tla_pkg::TLA_MODE_INTERRUPT;
    host.chan_mask = 2'h3;
    host.limits[0] = {11'h7ff, 11'h000, 11'h320};
    round(12'h320, 2'h0);
    check(pins, 16'h0082);
    round(12'h311, 2'h0);
    check(pins, 16'h0082);
    round(12'h30c, 2'h0);
    check(pins, 16'h0000);
    // diode faults on the external channel, low limit set above zero
    {host.mask_all, host.chan_mask} = 3'h0;
    host.limits[1].low = 11'h100;
    for (int k = 0; k < 3; k++) begin
      do_reset();
      round(12'h190, 2'(k + 1) & 2'h2 | 2'(k == 1));
    end
    for (int k = 0; k < 3; k++) begin
      do_reset();
      round(12'h190, k == 0 ? 2'h2 : (k == 1 ? 2'h1 : 2'h0));
      if (k == 2) begin
        round(12'h190, 2'h0);
      end
      check(bytes1, k == 2 ? 16'h3200 : 16'h0000);
      check(pins, k == 0 ? 16'h0101 : (k == 1 ? 16'h0110 : 16'h0000));
    end
    // settings load, every filter level
    for (int f = 0; f < 3; f++) begin
      host.strobe(1'b0, 6'h2a + 6'(f), 2'(f));
      check({ideality_factor, filter_level},
            {8'h00, 6'h2a + 6'(f), 2'(f)});
    end
    // filter levels one and two: a step from zero moves a quarter, an eighth
    for (int f = 1; f < 3; f++) begin
      do_reset();
      host.strobe(1'b0, 6'h12, 2'(f));
      round(12'h190, 2'h0);
      check(bytes1, f == 1 ? 16'h0c80 : 16'h0640);
    end
    finish_test();
  end
endmodule : tb_top

bind tla_alert_logic tla_alert_logic_assertions #(.NCH(NCH), .EXT(EXT))
  u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .meas_valid(meas_valid),
    .meas(meas), .alert_mode(alert_mode), .ext_range(ext_range),
    .mask_all(mask_all), .cfg_wr(cfg_wr), .ideality_wdata(ideality_wdata),
    .filter_wdata(filter_wdata), .temp_high_byte(temp_high_byte),
    .temp_low_byte(temp_low_byte), .ideality_factor(ideality_factor),
    .filter_level(filter_level), .crit_status(crit_status),
    .alert_comparator_pin_o(alert_comparator_pin_o),
    .alert_comparator_pin_oe(alert_comparator_pin_oe),
    .crit_pin_o(crit_pin_o), .crit_pin_oe(crit_pin_oe));

// ### tla_alert_logic.sv
// limit check, fault handling and alert pins of a two-channel sensor
`timescale 1ns/1ps
`include "tla_map.svh"

module tla_alert_logic #(
  parameter int NCH = `TLA_NUM_CH,
  parameter int EXT = `TLA_EXT_CH,
  parameter int QW = `TLA_QUEUE_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // converter results, one strobe per round of all channels
  input wire logic meas_valid,
  input tla_pkg::tla_meas_s [NCH-1:0] meas,
  // mode and masks
  input tla_pkg::tla_mode_e alert_mode,
  input wire logic ext_range,
  input wire logic mask_all,
  input wire logic [NCH-1:0] chan_mask,
  // limits
  input tla_pkg::tla_limits_s [NCH-1:0] limits,
  input wire logic [7:0] hysteresis,
  input wire logic [QW-1:0] alert_queue,
  input wire logic [QW-1:0] crit_queue,
  // external diode settings, loaded on cfg_wr
  input wire logic cfg_wr,
  input wire logic [5:0] ideality_wdata,
  input wire logic [1:0] filter_wdata,
  // status clear from the host read path
  input wire logic status_clr,
  // readings
  output logic [NCH-1:0][7:0] temp_high_byte,
  output logic [NCH-1:0][7:0] temp_low_byte,
  // settings to the analog front end
  output logic [5:0] ideality_factor,
  output logic [1:0] filter_level,
  // status
  output logic [NCH-1:0] high_status,
  output logic [NCH-1:0] low_status,
  output logic [NCH-1:0] crit_status,
  output logic fault_status,
  // open-drain pins, active low, enable high while pulling down
  output logic alert_comparator_pin_o,
  output logic alert_comparator_pin_oe,
  output logic crit_pin_o,
  output logic crit_pin_oe
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (NCH < 1 || EXT >= NCH || EXT < 0) begin
      $error("tla_alert_logic: channel parameters out of range");
    end
  end

  // ---------------------------------------------------------------
  // external diode settings
  // ---------------------------------------------------------------
  // ideality only feeds the front end; nothing here corrects for it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ideality_factor <= `TLA_IDEAL_RST;
      filter_level <= `TLA_FILT_OFF;
    end else if (cfg_wr) begin
      ideality_factor <= ideality_wdata;
      filter_level <= filter_wdata;
    end
  end

  // ---------------------------------------------------------------
  // fault decode
  // ---------------------------------------------------------------
  // negative pin to ground is no input here: the converter still sees
  // a diode and its result goes through as an ordinary reading
  wire ext_fault = meas[EXT].open_fault;
  wire ext_short = meas[EXT].short_low;

  // ---------------------------------------------------------------
  // digital filter on the external channel
  // ---------------------------------------------------------------
  // accumulator keeps three fraction bits so small steps are not lost
  logic signed [14:0] filt_acc;
  wire signed [14:0] filt_in = {meas[EXT].raw, 3'h0};
  wire signed [15:0] filt_diff = 16'(filt_in) - 16'(filt_acc);
  wire signed [15:0] filt_step1 = filt_diff >>> `TLA_FILT_L1_SHIFT;
  wire signed [15:0] filt_step2 = filt_diff >>> `TLA_FILT_L2_SHIFT;
  wire filt_l1 = (filter_level == `TLA_FILT_L1);
  wire filt_l2 = (filter_level == `TLA_FILT_L2);
  wire signed [15:0] filt_sum1 = 16'(filt_acc) + filt_step1;
  wire signed [15:0] filt_sum2 = 16'(filt_acc) + filt_step2;
  wire signed [14:0] next_filt_acc = filt_l1 ? filt_sum1[14:0] :
                                     filt_l2 ? filt_sum2[14:0] :
                                     filt_in;

  // a faulted round carries no temperature, so it must not pull the
  // filter toward garbage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      filt_acc <= '0;
    end else if (meas_valid && !ext_fault && !ext_short) begin
      filt_acc <= next_filt_acc;
    end
  end

  // ---------------------------------------------------------------
  // reading encoding
  // ---------------------------------------------------------------
  function automatic logic [10:0] to_code(input logic signed [11:0] r,
                                          input logic ext);
    logic signed [12:0] shifted;
    logic [10:0] top;
    shifted = ext ? (13'(r) + `TLA_EXT_OFFSET) : 13'(r);
    top = ext ? `TLA_EXT_MAX : `TLA_DEF_MAX;
    if (shifted < 0) begin
      to_code = '0;
    end else if (shifted > 13'(top)) begin
      to_code = top;
    end else begin
      to_code = shifted[10:0];
    end
  endfunction : to_code

  // ---------------------------------------------------------------
  // stage 1: capture codes of the round
  // ---------------------------------------------------------------
  logic [NCH-1:0][10:0] code;
  logic fault_q;
  logic stage1;
  logic stage2;
  logic [NCH-1:0][10:0] next_code;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_code
      wire signed [11:0] src = (g == EXT) ? next_filt_acc[14:3] : meas[g].raw;
      wire forced_zero = (g == EXT) && (ext_fault || ext_short);
      // faults and low shorts both read as the all-zero code
      assign next_code[g] = forced_zero ? `TLA_FAULT_CODE :
                            to_code(src, ext_range);
    end
  endgenerate

  // the external code takes this round's filter output, so a disabled
  // filter never shows a stale or reset reading that could raise a low alert
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      code <= '0;
      fault_q <= 1'b0;
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= meas_valid;
      stage2 <= stage1;
      if (meas_valid) begin
        code <= next_code;
        fault_q <= ext_fault;
      end
    end
  end

  // ---------------------------------------------------------------
  // reading bytes
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < NCH; g++) begin : g_bytes
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          temp_high_byte[g] <= '0;
          temp_low_byte[g] <= '0;
        end else if (stage1) begin
          temp_high_byte[g] <= code[g][10:3];
          temp_low_byte[g] <= {code[g][2:0], `TLA_LO_PAD};
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // limit comparisons
  // ---------------------------------------------------------------
  // hysteresis is whole degrees; moved to eighths so it lines up with
  // the code in either range
  wire [11:0] hyst_code = {1'b0, hysteresis, `TLA_HYST_FRAC};
  wire comp_mode = (alert_mode == tla_pkg::TLA_MODE_COMPARATOR);

  logic [NCH-1:0] over_hi;
  logic [NCH-1:0] at_hi;
  logic [NCH-1:0] under_lo;
  logic [NCH-1:0] at_crit;
  logic [NCH-1:0] below_hi_hyst;
  logic [NCH-1:0] below_crit_hyst;
  logic [NCH-1:0] chan_fault;
  logic [NCH-1:0] alert_hit;
  logic [NCH-1:0] alert_met;
  logic [NCH-1:0] crit_met;

  generate
    for (g = 0; g < NCH; g++) begin : g_cmp
      wire [11:0] code_w = {1'b0, code[g]};
      assign chan_fault[g] = (g == EXT) && fault_q;
      assign over_hi[g] = code[g] > limits[g].high;
      assign at_hi[g] = code[g] >= limits[g].high;
      // a faulted channel reads zero, which would look low against any low limit above zero
      assign under_lo[g] = (code[g] < limits[g].low) &&
                           !chan_fault[g];
      assign at_crit[g] = code[g] >= limits[g].crit;
      assign below_hi_hyst[g] = (code_w + hyst_code) <
                                {1'b0, limits[g].high};
      assign below_crit_hyst[g] = (code_w + hyst_code) <
                                  {1'b0, limits[g].crit};
      assign alert_hit[g] = comp_mode ? over_hi[g] :
                            (at_hi[g] || under_lo[g] ||
                             chan_fault[g]);

      tla_event_counter #(
        .QW(QW)
      ) u_alert_cnt (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sample(stage1),
        .hit(alert_hit[g]),
        .threshold(alert_queue),
        .met(alert_met[g])
      );

      tla_event_counter #(
        .QW(QW)
      ) u_crit_cnt (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sample(stage1),
        .hit(at_crit[g]),
        .threshold(crit_queue),
        .met(crit_met[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // qualified events of the round, evaluated at stage 2
  // ---------------------------------------------------------------
  wire [NCH-1:0] ev_hi = stage2 ? (alert_met & at_hi) : '0;
  wire [NCH-1:0] ev_lo = stage2 ? (alert_met & under_lo) : '0;
  wire ev_fault = stage2 && alert_met[EXT] && fault_q;
  wire [NCH-1:0] cmp_set = stage2 ? (alert_met & over_hi & ~chan_mask)
                                  : '0;
  wire all_below_hi = &below_hi_hyst;
  wire all_below_crit = &below_crit_hyst;
  wire [NCH-1:0] crit_set = stage2 ? crit_met : '0;

  // ---------------------------------------------------------------
  // comparator latch and critical latch
  // ---------------------------------------------------------------
  logic cmp_active;
  logic crit_active;
  wire next_cmp_active = (|cmp_set) ? 1'b1 :
                         (stage2 && all_below_hi) ? 1'b0 :
                         cmp_active;
  wire next_crit_active = (|crit_set) ? 1'b1 :
                          (stage2 && all_below_crit) ? 1'b0 :
                          crit_active;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmp_active <= 1'b0;
      crit_active <= 1'b0;
    end else begin
      cmp_active <= comp_mode && next_cmp_active;
      crit_active <= next_crit_active;
    end
  end

  // ---------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------
  // interrupt mode: high, low and fault bits sticky until the host clears,
  // a new event in the clear cycle wins; comparator mode: high bits follow the latch
  wire clr_int = status_clr && !comp_mode;
  wire [NCH-1:0] next_high_status =
    comp_mode ? (next_cmp_active ? (high_status | cmp_set) : '0)
              : (ev_hi | (clr_int ? '0 : high_status));
  wire [NCH-1:0] next_low_status =
    ev_lo | (clr_int ? '0 : low_status);
  wire next_fault_status =
    ev_fault | (!clr_int && fault_status);
  wire [NCH-1:0] next_crit_status =
    next_crit_active ? (crit_status | crit_set) : '0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      high_status <= '0;
      low_status <= '0;
      fault_status <= 1'b0;
      crit_status <= '0;
    end else begin
      high_status <= next_high_status;
      low_status <= next_low_status;
      fault_status <= next_fault_status;
      crit_status <= next_crit_status;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  wire [NCH-1:0] fault_vec = fault_status ? NCH'(1) << EXT : '0;
  wire int_pending = |((high_status | low_status | fault_vec) &
                       ~chan_mask);
  // the global mask only matters outside comparator mode
  wire alert_drive = comp_mode ? cmp_active
                               : (int_pending && !mask_all);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      alert_comparator_pin_oe <= 1'b0;
      crit_pin_oe <= 1'b0;
    end else begin
      alert_comparator_pin_oe <= alert_drive;
      crit_pin_oe <= crit_active;
    end
  end

  // open drain: only ever pulls low
  assign alert_comparator_pin_o = 1'b0;
  assign crit_pin_o = 1'b0;

endmodule : tla_alert_logic

// ### tla_alert_logic_assertions.sv
// concurrent checks on the ports of the limit and alert logic
`timescale 1ns/1ps
module tla_alert_logic_assertions #(
  parameter int NCH = 2,
  parameter int EXT = 1
) (
  // clock, reset and inputs
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic meas_valid,
  input tla_pkg::tla_meas_s [NCH-1:0] meas,
  input tla_pkg::tla_mode_e alert_mode,
  input wire logic ext_range,
  input wire logic mask_all,
  input wire logic cfg_wr,
  input wire logic [5:0] ideality_wdata,
  input wire logic [1:0] filter_wdata,
  // outputs
  input wire logic [NCH-1:0][7:0] temp_high_byte,
  input wire logic [NCH-1:0][7:0] temp_low_byte,
  input wire logic [5:0] ideality_factor,
  input wire logic [1:0] filter_level,
  input wire logic [NCH-1:0] crit_status,
  input wire logic alert_comparator_pin_o,
  input wire logic alert_comparator_pin_oe,
  input wire logic crit_pin_o,
  input wire logic crit_pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // internal channel has no filter lag, so its bytes follow two edges on
  wire signed [11:0] raw0 = meas[0].raw;
  wire [15:0] bytes0 = {temp_high_byte[0], temp_low_byte[0]};

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_pins_low;
    !alert_comparator_pin_o && !crit_pin_o;
  endproperty
  a_pins_low: assert property (p_pins_low)
    else $error("open-drain level not low");
  property p_low_pad;
    temp_low_byte[0][4:0] == 5'h00 && temp_low_byte[EXT][4:0] == 5'h00;
  endproperty
  a_low_pad: assert property (p_low_pad)
    else $error("unused low byte bits set");
  property p_def_top;
    meas_valid && !ext_range && raw0 > 12'sh3ff |-> ##2 bytes0 == 16'h7fe0;
  endproperty
  a_def_top: assert property (p_def_top)
    else $error("default range not clamped at top");
  property p_floor;
    meas_valid && (ext_range ? raw0 < 12'she00 : raw0 < 12'sh000)
      |-> ##2 bytes0 == 16'h0000;
  endproperty
  a_floor: assert property (p_floor)
    else $error("reading below floor not zero");
  property p_ext_sat;
    meas_valid && ext_range && raw0 > 12'sh5fe |-> ##2 bytes0 == 16'hffe0;
  endproperty
  a_ext_sat: assert property (p_ext_sat)
    else $error("extended range not saturated");
  property p_fault_zero;
    meas_valid && (meas[EXT].open_fault || meas[EXT].short_low)
      |-> ##2 {temp_high_byte[EXT], temp_low_byte[EXT]} == 16'h0000;
  endproperty
  a_fault_zero: assert property (p_fault_zero)
    else $error("faulted channel reading not zero");
  property p_crit_cause;
    $rose(crit_pin_oe) |-> $past(|crit_status);
  endproperty
  a_crit_cause: assert property (p_crit_cause)
    else $error("critical pin rose without status");
  property p_mask_all;
    (alert_mode == tla_pkg::TLA_MODE_INTERRUPT && mask_all)[*2]
      |-> !alert_comparator_pin_oe;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("masked alert pin still pulled");
  property p_cfg_load;
    cfg_wr |=> ideality_factor == $past(ideality_wdata)
      && filter_level == $past(filter_wdata);
  endproperty
  a_cfg_load: assert property (p_cfg_load)
    else $error("settings not loaded");

  // main scenarios reached
  c_crit: cover property (crit_pin_oe);
  c_cmp: cover property (alert_comparator_pin_oe && alert_mode);
  c_fault: cover property (meas_valid && meas[EXT].open_fault);
endmodule : tla_alert_logic_assertions

// ### tla_event_counter.sv
// consecutive measurement counter for one channel and one pin
`timescale 1ns/1ps
`include "tla_map.svh"

module tla_event_counter #(
  parameter int QW = `TLA_QUEUE_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // measurement
  input wire logic sample,
  input wire logic hit,
  input wire logic [QW-1:0] threshold,
  // result
  output logic met
);

  initial begin
    if (QW < 1 || QW > 8) begin
      $error("tla_event_counter: QW out of range");
    end
  end

  logic [QW-1:0] count;
  wire [QW-1:0] all_ones = {QW{1'b1}};
  wire [QW-1:0] thr_eff = (threshold == '0) ? QW'(1) : threshold;
  wire saturated = (count == all_ones);

  // any in-limit measurement breaks the run and restarts it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (sample) begin
      count <= hit ? (saturated ? count : count + QW'(1)) : '0;
    end
  end

  assign met = (count >= thr_eff);

endmodule : tla_event_counter

// ### tla_host_model.sv
// host controller model that owns the settings and strobes of the block
`timescale 1ns/1ps
module tla_host_model (
  // clock
  input wire logic ref_clk,
  // settings, held as levels
  output tla_pkg::tla_mode_e alert_mode,
  output logic ext_range,
  output logic mask_all,
  output logic [1:0] chan_mask,
  output tla_pkg::tla_limits_s [1:0] limits,
  output logic [7:0] hysteresis,
  output logic [2:0] alert_queue,
  output logic [2:0] crit_queue,
  // one-cycle strobes and their data
  output logic cfg_wr,
  output logic [5:0] ideality_wdata,
  output logic [1:0] filter_wdata,
  output logic status_clr
);
  // ---------------------------------------------------------------
  // idle settings: wide limits, nothing masked, filter off
  // ---------------------------------------------------------------
  initial begin
    alert_mode = tla_pkg::TLA_MODE_INTERRUPT;
    {ext_range, mask_all, chan_mask, cfg_wr, status_clr} = 6'h00;
    limits = {2{11'h7ff, 11'h000, 11'h7ff}};
    hysteresis = 8'h02;
    {alert_queue, crit_queue} = 6'h09;
    ideality_wdata = 6'h12;
    filter_wdata = 2'h0;
  end

  // strobe rises after an edge and is dropped after exactly one cycle
  task automatic strobe(input logic clr, input logic [5:0] ideal,
                        input logic [1:0] filt);
    @(posedge ref_clk);
    #1;
    status_clr = clr;
    cfg_wr = !clr;
    ideality_wdata = ideal; // callers keep 6'h12 except the settings-load loop
    filter_wdata = filt;
    @(posedge ref_clk);
    #1;
    {status_clr, cfg_wr} = 2'h0;
  endtask : strobe
endmodule : tla_host_model

// ### tla_map.svh
// constants for the temperature limit and alert logic
`ifndef TLA_MAP_SVH
`define TLA_MAP_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define TLA_NUM_CH 2
`define TLA_EXT_CH 1
`define TLA_RAW_W 12
`define TLA_CODE_W 11
`define TLA_IDEAL_W 6
`define TLA_QUEUE_W 3

// ---------------------------------------------------------------
// reading encoding
// ---------------------------------------------------------------
`define TLA_EXT_OFFSET 13'sh0200
`define TLA_DEF_MAX 11'h3ff
`define TLA_EXT_MAX 11'h7ff
`define TLA_FAULT_CODE 11'h000
`define TLA_LO_PAD 5'h00
`define TLA_HYST_FRAC 3'h0

// ---------------------------------------------------------------
// reset values and filter settings
// ---------------------------------------------------------------
`define TLA_IDEAL_RST 6'h12
`define TLA_FILT_OFF 2'h0
`define TLA_FILT_L1 2'h1
`define TLA_FILT_L2 2'h2
`define TLA_FILT_L1_SHIFT 2
`define TLA_FILT_L2_SHIFT 3
`define TLA_FILT_FRAC 3

`endif

// ### tla_pkg.sv
// types shared by the temperature limit and alert logic
package tla_pkg;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // limits of one channel, in the same encoding as the stored reading
  typedef struct packed {
    logic [10:0] high;
    logic [10:0] low;
    logic [10:0] crit;
  } tla_limits_s;

  // one conversion result of one channel from the converter
  typedef struct packed {
    logic signed [11:0] raw;   // eighths of a degree, signed
    logic open_fault;          // pins open or a pin shorted to supply
    logic short_low;           // pins shorted together or positive to ground
  } tla_meas_s;

  // alert pin behaviour
  typedef enum logic {
    TLA_MODE_INTERRUPT,
    TLA_MODE_COMPARATOR
  } tla_mode_e;

endpackage : tla_pkg
